/* File: hdl/ssc_pkg.sv */
// Package for the start-up sequencer: widths, codes, timing constants.
// Assumes a 40 MHz reference clock and 32 kHz ticks arriving as pulses.
package ssc_pkg;
  localparam int          SLOT_W            = 5;
  localparam int          PERIOD_SEL_W      = 2;
  localparam int          NUM_RAILS         = 12;
  localparam int          CFG_W             = 64;
  // Slot period in microseconds, per select code
  localparam int          SLOT_US_SEL0      = 500;
  localparam int          SLOT_US_SEL1      = 1000;
  localparam int          SLOT_US_SEL2      = 2000;
  localparam int          SLOT_US_SEL3      = 4000;
  // Tick rate in kHz; slot length in ticks derives from it
  localparam int          TICK_KHZ          = 32;
  localparam int          SLOT_TICKS_SEL0   = SLOT_US_SEL0 * TICK_KHZ / 1000;
  localparam int          SLOT_TICKS_SEL1   = SLOT_US_SEL1 * TICK_KHZ / 1000;
  localparam int          SLOT_TICKS_SEL2   = SLOT_US_SEL2 * TICK_KHZ / 1000;
  localparam int          SLOT_TICKS_SEL3   = SLOT_US_SEL3 * TICK_KHZ / 1000;
  // Long press in milliseconds, counted on the derived tick
  localparam int          LONG_PRESS_MS     = 4000;
  localparam int          LONG_PRESS_TICKS  = LONG_PRESS_MS * TICK_KHZ;
  localparam logic [0:0]  ADDR_MSB          = 1'h1;
  localparam logic [0:0]  HOLD_RESET        = 1'h0;
  // Config source codes
  localparam logic [1:0]  SRC_NONE          = 2'h0;
  localparam logic [1:0]  SRC_FUSE          = 2'h1;
  localparam logic [1:0]  SRC_SHADOW        = 2'h2;
  localparam logic [1:0]  SRC_FACTORY       = 2'h3;
  typedef enum logic [3:0] {
    SSC_OFF  = 4'b0001,
    SSC_LOAD = 4'b0010,
    SSC_SEQ  = 4'b0100,
    SSC_ON   = 4'b1000
  } ssc_state_e;
endpackage

/* File: hdl/ssc_startup_sequencer.sv */
// Start-up sequencer: config source, button decode, timed rail enables.
// Assumes all inputs synchronous to ref_clk; ticks are one-cycle pulses.
// What this block does
// - Every rail has a five-bit slot code
// - Zero slot code keeps rail off
// - Enable time is code times slot period
// - Period select: 500/1000/2000/4000 microseconds
// - Sequence ends at highest programmed slot
// - Level mode: high on, low off
// - Edge mode: falling edge turns on
// - Edge mode: four-second low turns off
// - Slave address is one plus three bits
// - Shadow cleared when main supply appears
// - Fuse pin at core: factory defaults load
// - Fuse pin low, hold 0, select 1, all bank enables set: fuses
// - Fuse pin low, hold 0, select 0: zero
// - Hold bit resets zero, keeps shadow contents
// - Host may write shadow while supply valid
// - Shadow start needs supply, pin low, hold
// - After fuse load, turn-on uses fuse config
// - Optionally load error-corrected fuse values
// - Sequencing and long-press count use derived tick
// - Untrimmed tick only in low-power cases
// - Low-supply and button debounce use untrimmed tick
`timescale 1ns/1ps
`default_nettype none
module ssc_startup_sequencer #(
  parameter int NUM_RAILS        = ssc_pkg::NUM_RAILS,
  parameter int CFG_W            = ssc_pkg::CFG_W,
  parameter int NUM_BANKS        = 10,
  parameter int LONG_PRESS_TICKS = ssc_pkg::LONG_PRESS_TICKS,
  parameter int DEBOUNCE_TICKS   = 1
) (
  input  wire  logic                                   ref_clk,
  input  wire  logic                                   srst,
  input  wire  logic                                   clk_en,
  input  wire  logic                                   tick_trim,
  input  wire  logic                                   tick_untrim,
  input  wire  logic                                   main_supply_valid,
  input  wire  logic                                   above_undervoltage,
  input  wire  logic                                   rails_low_power,
  input  wire  logic                                   fuse_supply_pin,
  input  wire  logic                                   shadow_hold_bit,
  input  wire  logic                                   fuse_load_select,
  input  wire  logic [NUM_BANKS-1:0]                   bank_load_enable,
  input  wire  logic                                   ecc_select,
  input  wire  logic [CFG_W-1:0]                       fuse_raw,
  input  wire  logic [CFG_W-1:0]                       fuse_corrected,
  input  wire  logic [CFG_W-1:0]                       factory_cfg,
  input  wire  logic                                   host_wr,
  input  wire  logic [CFG_W-1:0]                       host_wdata,
  input  wire  logic                                   power_button_pin,
  input  wire  logic                                   button_edge_mode,
  input  wire  logic [NUM_RAILS*ssc_pkg::SLOT_W-1:0]   slot_codes,
  input  wire  logic [ssc_pkg::PERIOD_SEL_W-1:0]       slot_period_select,
  input  wire  logic [2:0]                             slave_addr_bits,
  input  wire  logic                                   low_supply_raw,
  output var   logic [NUM_RAILS-1:0]                   rail_enable,
  output var   logic                                   seq_done,
  output var   logic                                   powered_on,
  output var   logic [3:0]                             slave_addr,
  output var   logic [CFG_W-1:0]                       config_shadow_regs,
  output var   logic [1:0]                             config_source,
  output var   logic                                   use_untrimmed,
  output var   logic                                   low_supply_irq,
  output var   logic                                   button_irq
);

  ssc_pkg::ssc_state_e state_reg;
  logic                tick_sel;
  logic                supply_prev_reg;
  logic                button_prev_reg;
  logic [15:0]         slot_len;
  logic [15:0]         sub_cnt_reg;
  logic [4:0]          slot_cnt_reg;
  logic [4:0]          last_slot;
  logic [31:0]         press_cnt_reg;
  logic                turn_on;
  logic                turn_off;
  logic                seq_run;
  logic [NUM_RAILS-1:0] rail_hit;
  logic [7:0]          lowsup_cnt_reg;
  logic [7:0]          btn_cnt_reg;

  // Clock source choice; untrimmed only when trimmed timing is unneeded
  assign tick_sel = (!above_undervoltage || rails_low_power) ? tick_untrim : tick_trim;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      use_untrimmed <= 1'h0;
    end else if (clk_en) begin
      use_untrimmed <= !above_undervoltage || rails_low_power;
    end
  end

  // Slot length in ticks from the period select
  always_comb begin
    case (slot_period_select)
      2'h0:    slot_len = 16'(ssc_pkg::SLOT_TICKS_SEL0);
      2'h1:    slot_len = 16'(ssc_pkg::SLOT_TICKS_SEL1);
      2'h2:    slot_len = 16'(ssc_pkg::SLOT_TICKS_SEL2);
      default: slot_len = 16'(ssc_pkg::SLOT_TICKS_SEL3);
    endcase
  end

  // Highest programmed slot; the sequence stops there, not at 31
  always_comb begin
    last_slot = 5'h00;
    for (int i = 0; i < NUM_RAILS; i++) begin
      if (slot_codes[i*ssc_pkg::SLOT_W +: ssc_pkg::SLOT_W] > last_slot) begin
        last_slot = slot_codes[i*ssc_pkg::SLOT_W +: ssc_pkg::SLOT_W];
      end
    end
  end

  // Button decode: level mode follows the pin, edge mode uses falling edge
  assign turn_on  = button_edge_mode ? (button_prev_reg && !power_button_pin)
                                     : power_button_pin;
  assign turn_off = button_edge_mode ? (press_cnt_reg >= 32'(LONG_PRESS_TICKS))
                                     : !power_button_pin;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      button_prev_reg <= 1'h1;
    end else if (clk_en) begin
      button_prev_reg <= power_button_pin;
    end
  end

  // Long-press counter on the trimmed derived tick, saturating
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      press_cnt_reg <= 32'h0;
    end else if (clk_en) begin
      if (power_button_pin || !button_edge_mode) begin
        press_cnt_reg <= 32'h0;
      end else if (tick_trim && press_cnt_reg < 32'(LONG_PRESS_TICKS)) begin
        press_cnt_reg <= press_cnt_reg + 32'h1;
      end
    end
  end

  // Shadow registers: cleared on supply arrival, then loaded per source
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      supply_prev_reg    <= 1'h0;
      config_shadow_regs <= '0;
      config_source      <= ssc_pkg::SRC_NONE;
    end else if (clk_en) begin
      supply_prev_reg <= main_supply_valid;
      if (main_supply_valid && !supply_prev_reg) begin
        config_shadow_regs <= '0;
        config_source      <= ssc_pkg::SRC_NONE;
      end else if (main_supply_valid && state_reg == ssc_pkg::SSC_LOAD) begin
        if (fuse_supply_pin) begin
          config_shadow_regs <= factory_cfg;
          config_source      <= ssc_pkg::SRC_FACTORY;
        end else if (shadow_hold_bit) begin
          config_source      <= ssc_pkg::SRC_SHADOW;
        end else if (fuse_load_select && &bank_load_enable) begin
          config_shadow_regs <= ecc_select ? fuse_corrected : fuse_raw;
          config_source      <= ssc_pkg::SRC_FUSE;
        end else begin
          config_shadow_regs <= '0;
          config_source      <= ssc_pkg::SRC_NONE;
        end
      end else if (host_wr && main_supply_valid) begin
        config_shadow_regs <= host_wdata;
      end
    end
  end

  // Sequence keeps running while in SEQ, the supply holds and no turn-off
  assign seq_run = (state_reg == ssc_pkg::SSC_SEQ) && !turn_off && main_supply_valid;

  // Power state machine; needs valid supply for any start
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ssc_pkg::SSC_OFF;
    end else if (clk_en) begin
      case (state_reg)
        ssc_pkg::SSC_OFF: begin
          if (turn_on && main_supply_valid) begin
            state_reg <= ssc_pkg::SSC_LOAD;
          end
        end
        ssc_pkg::SSC_LOAD: begin
          state_reg <= ssc_pkg::SSC_SEQ;
        end
        ssc_pkg::SSC_SEQ: begin
          if (!seq_run) begin
            state_reg <= ssc_pkg::SSC_OFF;
          end else if (slot_cnt_reg >= last_slot) begin
            state_reg <= ssc_pkg::SSC_ON;
          end
        end
        ssc_pkg::SSC_ON: begin
          if (turn_off || !main_supply_valid) begin
            state_reg <= ssc_pkg::SSC_OFF;
          end
        end
        default: state_reg <= ssc_pkg::SSC_OFF;
      endcase
    end
  end

  // Slot timer; counts only while running and short of the last slot, so
  // unused slots past the highest code are never waited out
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sub_cnt_reg  <= 16'h0;
      slot_cnt_reg <= 5'h00;
    end else if (clk_en) begin
      if (state_reg == ssc_pkg::SSC_LOAD) begin
        sub_cnt_reg  <= 16'h0;
        slot_cnt_reg <= 5'h00;
      end else if (seq_run && slot_cnt_reg < last_slot && tick_sel) begin
        if (sub_cnt_reg + 16'h1 >= slot_len) begin
          sub_cnt_reg  <= 16'h0;
          slot_cnt_reg <= slot_cnt_reg + 5'h01;
        end else begin
          sub_cnt_reg <= sub_cnt_reg + 16'h1;
        end
      end
    end
  end

  // Status flags; powered_on rises on the first sequencing cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seq_done   <= 1'h0;
      powered_on <= 1'h0;
    end else if (clk_en) begin
      if (state_reg == ssc_pkg::SSC_OFF) begin
        seq_done   <= 1'h0;
        powered_on <= 1'h0;
      end else if (state_reg == ssc_pkg::SSC_SEQ) begin
        powered_on <= 1'h1;
        if (seq_run && slot_cnt_reg >= last_slot) begin
          seq_done <= 1'h1;
        end
      end
    end
  end

  // Per-rail compare; equal codes rise together, zero never rises
  for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail
    logic [ssc_pkg::SLOT_W-1:0] code;
    assign code = slot_codes[g*ssc_pkg::SLOT_W +: ssc_pkg::SLOT_W];
    assign rail_hit[g] = (code != 5'h00) && (slot_cnt_reg >= code);
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        rail_enable[g] <= 1'h0;
      end else if (clk_en) begin
        rail_enable[g] <= (state_reg == ssc_pkg::SSC_SEQ || state_reg == ssc_pkg::SSC_ON)
                          && rail_hit[g];
      end
    end
  end

  // Slave address: fixed top bit over the programmed low bits
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      slave_addr <= {ssc_pkg::ADDR_MSB, 3'h0};
    end else if (clk_en) begin
      slave_addr <= {ssc_pkg::ADDR_MSB, slave_addr_bits};
    end
  end

  // Interrupt debounce for these two counts untrimmed ticks only; the
  // trimmed tick may be gone in the very states that raise them
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lowsup_cnt_reg <= 8'h0;
      low_supply_irq <= 1'h0;
    end else if (clk_en) begin
      if (low_supply_raw == low_supply_irq) begin
        lowsup_cnt_reg <= 8'h0;
      end else if (tick_untrim) begin
        if (lowsup_cnt_reg + 8'h1 >= 8'(DEBOUNCE_TICKS)) begin
          low_supply_irq <= low_supply_raw;
          lowsup_cnt_reg <= 8'h0;
        end else begin
          lowsup_cnt_reg <= lowsup_cnt_reg + 8'h1;
        end
      end
    end
  end

  // Button interrupt reports the pin held low, on the same untrimmed tick
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      btn_cnt_reg <= 8'h0;
      button_irq  <= 1'h0;
    end else if (clk_en) begin
      if (!power_button_pin == button_irq) begin
        btn_cnt_reg <= 8'h0;
      end else if (tick_untrim) begin
        if (btn_cnt_reg + 8'h1 >= 8'(DEBOUNCE_TICKS)) begin
          button_irq  <= !power_button_pin;
          btn_cnt_reg <= 8'h0;
        end else begin
          btn_cnt_reg <= btn_cnt_reg + 8'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: bench/ssc_startup_sequencer_assertions.sv */
// Port checker for the start-up sequencer.
// Assumes it is bound into the sequencer; clk_en may pause it.
`timescale 1ns/1ps
`default_nettype none
module ssc_seq_checker #(
  parameter int NUM_RAILS = 12,
  parameter int CFG_W     = 64
) (
  input wire logic                                 ref_clk,
  input wire logic                                 srst,
  input wire logic                                 clk_en,
  input wire logic                                 tick_untrim,
  input wire logic                                 main_supply_valid,
  input wire logic                                 fuse_supply_pin,
  input wire logic                                 shadow_hold_bit,
  input wire logic                                 power_button_pin,
  input wire logic                                 button_edge_mode,
  input wire logic [NUM_RAILS*ssc_pkg::SLOT_W-1:0] slot_codes,
  input wire logic [2:0]                           slave_addr_bits,
  input wire logic [NUM_RAILS-1:0]                 rail_enable,
  input wire logic                                 seq_done,
  input wire logic                                 powered_on,
  input wire logic [3:0]                           slave_addr,
  input wire logic                                 low_supply_irq,
  input wire logic                                 button_irq,
  input wire logic [1:0]                           config_source
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [NUM_RAILS-1:0] zero_mask;
  logic [1:0]           src_exp;
  // Rails left out of the sequence by a zero code
  always_comb begin
    for (int i = 0; i < NUM_RAILS; i++)
      zero_mask[i] = slot_codes[5*i +: 5] == 5'h00;
  end
  // Only the fixed sources; the fuse case may be refused by the bank enables
  assign src_exp = fuse_supply_pin ? ssc_pkg::SRC_FACTORY : ssc_pkg::SRC_SHADOW;
  addr_map_a: assert property (!$past(srst) && $past(clk_en) |-> slave_addr == {ssc_pkg::ADDR_MSB, $past(slave_addr_bits)})
    else $error("slave address wrong");
  zero_off_a: assert property ((rail_enable & $past(zero_mask)) == '0)
    else $error("zero-code rail enabled");
  equal_slot_a: assert property (slot_codes[4:0] == slot_codes[9:5] |-> rail_enable[0] == rail_enable[1])
    else $error("equal codes split");
  seq_end_a: assert property ($rose(seq_done) |-> (rail_enable | zero_mask) == '1)
    else $error("done before last rail");
  level_on_a: assert property (!button_edge_mode && power_button_pin && main_supply_valid && !powered_on
    |-> ##[1:4] powered_on) else $error("level turn-on missing");
  level_off_a: assert property (!button_edge_mode && !power_button_pin && powered_on |-> ##[1:3] !powered_on)
    else $error("level turn-off missing");
  rails_drop_a: assert property ($fell(powered_on) |-> ##[0:2] rail_enable == '0)
    else $error("rails stay after off");
  source_fix_a: assert property ($changed(config_source) && config_source != ssc_pkg::SRC_NONE
    && (fuse_supply_pin || shadow_hold_bit) |-> config_source == src_exp) else $error("wrong source");
  irq_tick_a: assert property (($changed(low_supply_irq) || $changed(button_irq)) |-> $past(tick_untrim))
    else $error("irq moved off untrimmed tick");
  freeze_a: assert property (!clk_en |=> $stable(slave_addr) && $stable(powered_on) && $stable(rail_enable))
    else $error("state moved while frozen");
  seq_done_c: cover property ($rose(seq_done));
  turn_on_c: cover property ($rose(powered_on));
  turn_off_c: cover property ($fell(powered_on));
endmodule
`default_nettype wire

/* File: bench/ssc_far_model.sv */
// Far-side model: oscillator ticks and the host's fuse bank enables.
// Assumes a free-running ref_clk; ticks are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module ssc_far_model (
  input  wire logic       ref_clk,
  input  wire logic       all_banks,
  output var  logic       tick_trim,
  output var  logic       tick_untrim,
  output var  logic [9:0] bank_load_enable
);
  int tc = 0;
  int uc = 0;
  // Two free-running dividers of unequal rate; ticks coincide every twelfth cycle
  always @(negedge ref_clk) begin
    tc = (tc == 3) ? 0 : tc + 1;
    uc = (uc == 5) ? 0 : uc + 1;
  end
  assign tick_trim = tc == 0;
  assign tick_untrim = uc == 0;
  // Host sets every bank before a fuse load, unless told to leave one out
  assign bank_load_enable = all_banks ? 10'h3ff : 10'h1ff;
endmodule
`default_nettype wire

/* File: bench/tb_ssc_startup_sequencer.sv */
// Bench for the start-up sequencer: address, sources, slots, button, ticks.
// Assumes the far-side model makes the ticks and bank enables.
`timescale 1ns/1ps
`default_nettype none
module tb_ssc_startup_sequencer;
  localparam logic [63:0] FACT = 64'h0f0f_1234_5678_9abc;
  localparam logic [63:0] HOST = 64'ha5a5_0bad_f00d_5a5a;
  logic ref_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, tick_trim, tick_untrim;
  logic main_supply_valid = 1'b1, above_undervoltage = 1'b1, rails_low_power = 1'b0;
  logic fuse_supply_pin = 1'b0, shadow_hold_bit = 1'b0, fuse_load_select = 1'b0, ecc_select = 1'b0;
  logic host_wr = 1'b0, power_button_pin = 1'b0, button_edge_mode = 1'b0, low_supply_raw = 1'b0;
  logic all_banks = 1'b1;
  logic [9:0] bank_load_enable;
  logic [63:0] fuse_raw = 64'h1111_2222_3333_4444, fuse_corrected = 64'h5555_6666_7777_8888;
  logic [63:0] factory_cfg = FACT, host_wdata = HOST, config_shadow_regs;
  logic [59:0] slot_codes = '0;
  logic [1:0] slot_period_select = 2'h0, config_source;
  logic [2:0] slave_addr_bits = 3'h0;
  logic [11:0] rail_enable;
  logic [3:0] slave_addr;
  logic seq_done, powered_on, use_untrimmed, low_supply_irq, button_irq;
  int n_fail = 0, n_compared = 0, n_cyc = 0, tick_cnt = 0, t0, k, ln, m;
  ssc_startup_sequencer #(.LONG_PRESS_TICKS(8)) dut (.*);
  ssc_far_model far (.ref_clk(ref_clk), .all_banks(all_banks), .tick_trim(tick_trim),
    .tick_untrim(tick_untrim), .bank_load_enable(bank_load_enable));
  always #12.5 ref_clk = ~ref_clk;
  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Trimmed ticks for slot timing; a cycle ceiling cuts a hang short
  always @(posedge ref_clk) begin
    tick_cnt <= tick_cnt + int'(tick_trim);
    n_cyc <= n_cyc + 1;
    if (n_cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  // Fresh supply, optional host write, then a level-mode turn-on
  task automatic src_case(logic pin, hold, sel, banks, ecc, logic [1:0] src, logic [63:0] cfg);
    {power_button_pin, main_supply_valid} = 2'h0;
    {fuse_supply_pin, shadow_hold_bit, fuse_load_select, all_banks, ecc_select} = {pin, hold, sel, banks, ecc};
    cyc(4);
    main_supply_valid = 1'b1;
    cyc(2);
    chk("shadow_clear", config_shadow_regs, 64'h0);
    host_wr = hold;
    cyc(1);
    host_wr = 1'b0;
    cyc(1);
    if (hold)
      chk("host_write", config_shadow_regs, HOST);
    power_button_pin = 1'b1;
    cyc(6);
    chk("source", config_source, src);
    chk("shadow", config_shadow_regs, cfg);
  endtask
  initial begin
    cyc(3);
    srst = 1'b0;
    for (int a = 0; a < 8; a++) begin
      slave_addr_bits = 3'(a);
      cyc(2);
      chk("slave_addr", slave_addr, 64'h8 + a);
    end
    // Enable low freezes all state; the address must not follow its bits
    {clk_en, slave_addr_bits} = 4'h2;
    cyc(3);
    chk("freeze", slave_addr, 64'hf);
    clk_en = 1'b1;
    cyc(2);
    chk("unfreeze", slave_addr, 64'ha);
    src_case(1, 1, 1, 1, 0, 2'h3, FACT);
    src_case(0, 0, 1, 1, 0, 2'h1, fuse_raw);
    src_case(0, 0, 1, 1, 1, 2'h1, fuse_corrected);
    src_case(0, 0, 0, 1, 0, 2'h0, 64'h0);
    src_case(0, 0, 1, 0, 0, 2'h0, 64'h0);
    src_case(0, 1, 0, 1, 0, 2'h2, HOST);
    // Rails 0 and 1 share slot 2, rail 2 is last, the rest stay out
    for (int s = 0; s < 4; s++) begin
      power_button_pin = 1'b0;
      {ln, m} = {32'(16 << s), 32'((s == 0) ? 31 : 3)};
      slot_period_select = 2'(s);
      slot_codes[14:0] = {5'(m), 5'h02, 5'h02};
      cyc(4);
      t0 = tick_cnt;
      power_button_pin = 1'b1;
      for (k = 0; k < 9000 && rail_enable[0] !== 1'b1; k++)
        cyc(1);
      chk("rise_ticks", 64'((tick_cnt - t0) inside {[2*ln:2*ln+1]}), 64'h1);
      chk("pair", rail_enable, 12'h003);
      for (k = 0; k < 9000 && seq_done !== 1'b1; k++)
        cyc(1);
      chk("done_ticks", 64'((tick_cnt - t0) inside {[m*ln:m*ln+1]}), 64'h1);
      chk("rails", rail_enable, 12'h007);
    end
    // Drop to off in level mode first, so the falling edge has work to do
    power_button_pin = 1'b0;
    cyc(4);
    // Short press turns on; a long hold turns off; release does nothing
    {button_edge_mode, power_button_pin} = 2'h3;
    cyc(6);
    chk("edge_idle", powered_on, 1'b0);
    power_button_pin = 1'b0;
    cyc(2);
    power_button_pin = 1'b1;
    cyc(6);
    chk("edge_on", powered_on, 1'b1);
    power_button_pin = 1'b0;
    cyc(24);
    chk("hold_short", powered_on, 1'b1);
    cyc(16);
    chk("hold_long", powered_on, 1'b0);
    power_button_pin = 1'b1;
    cyc(6);
    chk("rise_no_on", powered_on, 1'b0);
    // Low-power cases pick the untrimmed tick; irqs debounce on it
    above_undervoltage = 1'b0;
    cyc(3);
    chk("untrim_uv", use_untrimmed, 1'b1);
    {above_undervoltage, rails_low_power} = 2'h3;
    cyc(3);
    chk("untrim_lp", use_untrimmed, 1'b1);
    {rails_low_power, low_supply_raw, power_button_pin} = 3'h2;
    cyc(20);
    chk("trim", use_untrimmed, 1'b0);
    chk("irqs", {low_supply_irq, button_irq}, 2'h3);
    print_verdict();
  end
endmodule
bind ssc_startup_sequencer ssc_seq_checker #(.NUM_RAILS(NUM_RAILS), .CFG_W(CFG_W)) chk_i (.*);
`default_nettype wire
